// ---- inc/pwm_chan_pkg.sv ----
// constants and types shared by the pwm channel block
// assumes a single 50 MHz system clock and no register bus
`default_nettype none
package pwm_chan_pkg;
    localparam int CNT_W = 16;
    localparam int PRE_W = 4;
    localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
    localparam logic [CNT_W-1:0] CNT_FIRST = 16'h0000;
    localparam logic [CNT_W-1:0] CNT_RESTART = 16'h0001;
    localparam logic [CNT_W-1:0] CNT_IMM_MAX = 16'h0001;
    localparam logic [CNT_W-1:0] PRD_RST = 16'h0000;
    localparam logic [CNT_W-1:0] DTY_RST = 16'h0000;
    localparam logic [PRE_W-1:0] PRE_RST = 4'h0;
    localparam logic [10:0] DIV_RST = 11'h000;
    localparam int CLK_MHZ = 50;
    // channel state, one-hot
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_FIRST = 3'b010,
        ST_RUN = 3'b100
    } chan_state_t;
endpackage
`default_nettype wire

// ---- rtl/pwm_clk_tick.sv ----
// clock tick generator: one-cycle pulse at clk / 2^sel for sel up to 11, clk / 2^11 for any larger sel
// assumes sel is a quasi-static control on the same clock
`default_nettype none
module pwm_clk_tick
    import pwm_chan_pkg::*;
(
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic run_in,
    input wire logic [PRE_W-1:0] sel_in,
    output logic tick_out
);
    logic [10:0] div_r;
    logic [10:0] div_nxt;
    logic [10:0] mask;

    // free divider, cleared while the channel is stopped
    always_comb begin
        div_nxt = run_in ? div_r + 11'h001 : DIV_RST;
        // sel above 10 wraps to all ones, the slowest usable tick
        mask = (11'h001 << sel_in) - 11'h001;
        tick_out = run_in && ((div_r & mask) == mask);
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            div_r <= DIV_RST;
        end else begin
            div_r <= div_nxt;
        end
    end
endmodule
`default_nettype wire

// ---- rtl/pwm_channel_update_logic.sv ----
// one pwm channel with buffered period/duty update and status flag
// assumes control strobes come from logic on CLK_IN, one cycle wide
`default_nettype none
module pwm_channel_update_logic
    import pwm_chan_pkg::*;
(
    input wire logic CLK_IN,
    input wire logic RESETN_IN,
    input wire logic ENABLE_IN,
    input wire logic DISABLE_IN,
    input wire logic CENTER_IN,
    input wire logic POL_IN,
    input wire logic [PRE_W-1:0] CLK_SEL_IN,
    input wire logic PRD_WR_IN,
    input wire logic [CNT_W-1:0] PRD_IN,
    input wire logic DTY_WR_IN,
    input wire logic [CNT_W-1:0] DTY_IN,
    input wire logic UPD_WR_IN,
    input wire logic UPD_SEL_PRD_IN,
    input wire logic [CNT_W-1:0] UPD_IN,
    output logic [CNT_W-1:0] CHANNEL_COUNTER_VALUE_OUT,
    output logic [CNT_W-1:0] CHANNEL_PERIOD_SETTING_OUT,
    output logic [CNT_W-1:0] CHANNEL_DUTY_SETTING_OUT,
    output logic CHANNEL_ACTIVE_FLAG_OUT,
    output logic UPD_PENDING_OUT,
    output logic PWM_OUT
);
    chan_state_t state_r, state_nxt;
    logic [CNT_W-1:0] cnt_r, cnt_nxt;
    logic [CNT_W-1:0] prd_r, prd_nxt;
    logic [CNT_W-1:0] dty_r, dty_nxt;
    logic [CNT_W-1:0] upd_r, upd_nxt;
    logic upd_prd_r, upd_prd_nxt;
    logic pend_r, pend_nxt;
    logic flag_r, flag_nxt;
    logic tick_seen_r, tick_seen_nxt;
    logic down_r, down_nxt;
    logic out_r, out_nxt;
    logic run;
    logic tick;
    logic period_end;
    logic wave;

    assign run = (state_r != ST_IDLE);

    pwm_clk_tick u_tick (
        .clk_in(CLK_IN),
        .resetn_in(RESETN_IN),
        .run_in(run),
        .sel_in(CLK_SEL_IN),
        .tick_out(tick)
    );

    // period end: left reaches prd, center returns to zero going down
    always_comb begin
        if (CENTER_IN) begin
            period_end = tick && down_r && (cnt_r <= CNT_RESTART);
        end else begin
            period_end = tick && (cnt_r >= prd_r);
        end
    end

    // channel state and counter
    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        down_nxt = down_r;
        tick_seen_nxt = tick_seen_r;
        flag_nxt = flag_r;
        unique case (state_r)
            ST_IDLE: begin
                if (ENABLE_IN) begin
                    state_nxt = ST_FIRST;
                    cnt_nxt = CNT_FIRST;
                    down_nxt = 1'b0;
                    tick_seen_nxt = 1'b0;
                    flag_nxt = 1'b1;
                end
            end
            ST_FIRST, ST_RUN: begin
                if (tick) begin
                    tick_seen_nxt = 1'b1;
                end
                if (period_end) begin
                    state_nxt = ST_RUN;
                    cnt_nxt = CENTER_IN ? CNT_FIRST : CNT_RESTART;
                    down_nxt = 1'b0;
                end else if (tick) begin
                    if (CENTER_IN && !down_r && cnt_r >= prd_r) begin
                        down_nxt = 1'b1;
                        cnt_nxt = cnt_r - 16'h0001;
                    end else if (CENTER_IN && down_r) begin
                        cnt_nxt = cnt_r - 16'h0001;
                    end else begin
                        cnt_nxt = cnt_r + 16'h0001;
                    end
                end
                if (DISABLE_IN) begin
                    // early disable stops the line, flag stays set
                    state_nxt = ST_IDLE;
                    cnt_nxt = CNT_RST;
                    flag_nxt = !tick_seen_r ? 1'b1 : 1'b0;
                end
            end
        endcase
    end

    // buffered update path; direct writes load the settings
    always_comb begin
        prd_nxt = PRD_WR_IN ? PRD_IN : prd_r;
        dty_nxt = DTY_WR_IN ? DTY_IN : dty_r;
        upd_nxt = upd_r;
        upd_prd_nxt = upd_prd_r;
        pend_nxt = pend_r;
        if (pend_r && period_end) begin
            pend_nxt = 1'b0;
            if (upd_prd_r && prd_r != PRD_RST) begin
                prd_nxt = upd_r;
            end else if (!upd_prd_r) begin
                dty_nxt = upd_r;
            end
        end
        if (UPD_WR_IN) begin
            // counter at 0/1 bypasses the buffer, as the silicon does
            if (cnt_r <= CNT_IMM_MAX) begin
                pend_nxt = 1'b0;
                if (UPD_SEL_PRD_IN && prd_r != PRD_RST) begin
                    prd_nxt = UPD_IN;
                end else if (!UPD_SEL_PRD_IN) begin
                    dty_nxt = UPD_IN;
                end
            end else begin
                pend_nxt = 1'b1;
                upd_nxt = UPD_IN;
                upd_prd_nxt = UPD_SEL_PRD_IN;
            end
        end
    end

    // waveform: plain compare in center mode, left mode gates duty 0 to inactive
    always_comb begin
        if (CENTER_IN) begin
            wave = (cnt_r < dty_r);
        end else begin
            wave = (cnt_r <= dty_r) && (dty_r > CNT_RESTART - 16'h0001);
        end
        out_nxt = (state_nxt != ST_IDLE) ? (wave ^ POL_IN) : POL_IN;
    end

    always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            state_r <= ST_IDLE;
            cnt_r <= CNT_RST;
            down_r <= 1'b0;
            tick_seen_r <= 1'b0;
            flag_r <= 1'b0;
            prd_r <= PRD_RST;
            dty_r <= DTY_RST;
            upd_r <= CNT_RST;
            upd_prd_r <= 1'b0;
            pend_r <= 1'b0;
            out_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            down_r <= down_nxt;
            tick_seen_r <= tick_seen_nxt;
            flag_r <= flag_nxt;
            prd_r <= prd_nxt;
            dty_r <= dty_nxt;
            upd_r <= upd_nxt;
            upd_prd_r <= upd_prd_nxt;
            pend_r <= pend_nxt;
            out_r <= out_nxt;
        end
    end

    assign CHANNEL_COUNTER_VALUE_OUT = cnt_r;
    assign CHANNEL_PERIOD_SETTING_OUT = prd_r;
    assign CHANNEL_DUTY_SETTING_OUT = dty_r;
    assign CHANNEL_ACTIVE_FLAG_OUT = flag_r;
    assign UPD_PENDING_OUT = pend_r;
    assign PWM_OUT = out_r;
endmodule
`default_nettype wire

// ---- dv/pwm_update_checker_assertions.sv ----
// port-level checker for the pwm channel update block
// assumes one clock domain; bound to the block's top module
`default_nettype none
module pwm_update_checker
    import pwm_chan_pkg::*;
(
    input wire logic CLK_IN,
    input wire logic RESETN_IN,
    input wire logic CENTER_IN,
    input wire logic POL_IN,
    input wire logic PRD_WR_IN,
    input wire logic DTY_WR_IN,
    input wire logic UPD_WR_IN,
    input wire logic UPD_SEL_PRD_IN,
    input wire logic [CNT_W-1:0] UPD_IN,
    input wire logic [CNT_W-1:0] CHANNEL_COUNTER_VALUE_OUT,
    input wire logic [CNT_W-1:0] CHANNEL_PERIOD_SETTING_OUT,
    input wire logic [CNT_W-1:0] CHANNEL_DUTY_SETTING_OUT,
    input wire logic CHANNEL_ACTIVE_FLAG_OUT,
    input wire logic UPD_PENDING_OUT,
    input wire logic PWM_OUT
);
    // short aliases keep the properties readable
    wire logic [CNT_W-1:0] cnt = CHANNEL_COUNTER_VALUE_OUT;
    wire logic [CNT_W-1:0] prd = CHANNEL_PERIOD_SETTING_OUT;
    wire logic [CNT_W-1:0] dty = CHANNEL_DUTY_SETTING_OUT;
    wire logic act = CHANNEL_ACTIVE_FLAG_OUT;
    wire logic wr_d = UPD_WR_IN && !UPD_SEL_PRD_IN;
    default clocking cb @(posedge CLK_IN);
    endclocking
    default disable iff (!RESETN_IN);
    a_imm_duty: assert property (wr_d && cnt <= CNT_IMM_MAX
        |=> dty == $past(UPD_IN) && !UPD_PENDING_OUT) else $error("no imm");
    a_zero_prd: assert property (UPD_WR_IN && UPD_SEL_PRD_IN
        && prd == 16'h0000 && !PRD_WR_IN |=> prd == 16'h0000)
        else $error("zero period changed");
    a_first_zero: assert property ($rose(act) |-> cnt == CNT_FIRST)
        else $error("first count not zero");
    a_wrap_one: assert property (act && $past(act) && !CENTER_IN
        && $past(!CENTER_IN) && cnt < $past(cnt) |-> cnt == CNT_RESTART)
        else $error("restart not one");
    a_duty0_still: assert property (act && $past(act, 2) && !CENTER_IN
        && dty == 16'h0000 && $past(dty) == 16'h0000
        && $past(dty, 2) == 16'h0000 && $stable(POL_IN)
        |-> $stable(PWM_OUT)) else $error("duty zero toggles");
    a_defer_duty: assert property (wr_d && cnt > CNT_IMM_MAX
        && !DTY_WR_IN |=> UPD_PENDING_OUT && $stable(dty))
        else $error("update not deferred");
endmodule
bind pwm_channel_update_logic pwm_update_checker chk_u (
    .CLK_IN(CLK_IN),
    .RESETN_IN(RESETN_IN),
    .CENTER_IN(CENTER_IN),
    .POL_IN(POL_IN),
    .PRD_WR_IN(PRD_WR_IN),
    .DTY_WR_IN(DTY_WR_IN),
    .UPD_WR_IN(UPD_WR_IN),
    .UPD_SEL_PRD_IN(UPD_SEL_PRD_IN),
    .UPD_IN(UPD_IN),
    .CHANNEL_COUNTER_VALUE_OUT(CHANNEL_COUNTER_VALUE_OUT),
    .CHANNEL_PERIOD_SETTING_OUT(CHANNEL_PERIOD_SETTING_OUT),
    .CHANNEL_DUTY_SETTING_OUT(CHANNEL_DUTY_SETTING_OUT),
    .CHANNEL_ACTIVE_FLAG_OUT(CHANNEL_ACTIVE_FLAG_OUT),
    .UPD_PENDING_OUT(UPD_PENDING_OUT),
    .PWM_OUT(PWM_OUT)
);
`default_nettype wire

// ---- dv/test_pwm_channel_update_logic.sv ----
// self-checking bench for the pwm channel update block
// assumes design sources and checker are compiled before it
`default_nettype none
module test_pwm_channel_update_logic
    import pwm_chan_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic CLK_IN = 1'h0;
    logic RESETN_IN = 1'h0;
    logic en = 1'h0, dis = 1'h0, p_wr = 1'h0, d_wr = 1'h0, u_wr = 1'h0;
    logic u_sel = 1'h0;
    logic ctr = 1'h0, pol = 1'h0;
    logic [CNT_W-1:0] val = 16'h0000;
    logic [CNT_W-1:0] cnt, prd, dty;
    logic act, pend, pwm;
    int error_cnt = 0, n_compared = 0;
    // 50 MHz clock
    always #10 CLK_IN = ~CLK_IN;
    // one shared data bus; tick at clk/8 so counts hold eight cycles
    pwm_channel_update_logic dut_u (
        .CLK_IN(CLK_IN), .RESETN_IN(RESETN_IN), .ENABLE_IN(en),
        .DISABLE_IN(dis), .CENTER_IN(ctr), .POL_IN(pol),
        .CLK_SEL_IN(4'h3), .PRD_WR_IN(p_wr), .PRD_IN(val),
        .DTY_WR_IN(d_wr), .DTY_IN(val), .UPD_WR_IN(u_wr),
        .UPD_SEL_PRD_IN(u_sel), .UPD_IN(val),
        .CHANNEL_COUNTER_VALUE_OUT(cnt),
        .CHANNEL_PERIOD_SETTING_OUT(prd),
        .CHANNEL_DUTY_SETTING_OUT(dty),
        .CHANNEL_ACTIVE_FLAG_OUT(act), .UPD_PENDING_OUT(pend),
        .PWM_OUT(pwm)
    );
    task automatic chk(input logic [CNT_W-1:0] got, exp);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic final_report();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // 0/1 direct period/duty, 2/3 buffered period/duty, 4 start, 5 stop
    task automatic req(input int k, input logic [CNT_W-1:0] v);
        @(posedge CLK_IN);
        val <= v;
        u_sel <= (k == 2);
        p_wr <= (k == 0);
        d_wr <= (k == 1);
        u_wr <= (k == 2 || k == 3);
        en <= (k == 4);
        dis <= (k == 5);
        @(posedge CLK_IN);
        {p_wr, d_wr, u_wr, en, dis} <= 5'h00;
        @(negedge CLK_IN);
    endtask
    // wait until the counter steps onto v, so it holds for a while
    task automatic wait_cnt(input logic [CNT_W-1:0] v);
        logic [CNT_W-1:0] prev;
        prev = cnt;
        for (int i = 0; i < 400; i++) begin
            @(negedge CLK_IN);
            if (cnt === v && prev !== v) begin
                return;
            end
            prev = cnt;
        end
        error_cnt++;
        final_report();
    endtask
    initial begin
        repeat (8) @(posedge CLK_IN);
        RESETN_IN <= 1'h1;
        @(negedge CLK_IN);
        req(2, 16'h0009);
        chk(prd, 16'h0000);
        req(3, 16'h0005);
        chk(dty, 16'h0005);
        req(0, 16'h0004);
        req(4, 16'h0000);
        chk(act, 1'h1);
        chk(cnt, CNT_FIRST);
        wait_cnt(16'h0002);
        req(3, 16'h0003);
        chk(dty, 16'h0005);
        chk(pend, 1'h1);
        wait_cnt(16'h0001);
        chk(dty, 16'h0003);
        chk(pend, 1'h0);
        req(3, 16'h0002);
        chk(dty, 16'h0002);
        req(2, 16'h0006);
        chk(prd, 16'h0006);
        // duty zero must hold the line inactive over a whole period
        req(1, 16'h0000);
        repeat (4) @(negedge CLK_IN);
        for (int i = 0; i < 60; i++) begin
            @(negedge CLK_IN);
            chk(pwm, 1'h0);
        end
        req(5, 16'h0000);
        chk(act, 1'h0);
        // stop before the first tick: line idles, flag is left set
        req(4, 16'h0000);
        req(5, 16'h0000);
        repeat (20) @(negedge CLK_IN);
        chk(act, 1'h1);
        chk(pwm, 1'h0);
        chk(cnt, CNT_FIRST);
        // center mode with inverted line; mode changes only while idle
        @(posedge CLK_IN);
        ctr <= 1'h1;
        pol <= 1'h1;
        repeat (2) @(negedge CLK_IN);
        chk(pwm, 1'h1);
        req(1, 16'h0003);
        req(4, 16'h0000);
        chk(cnt, CNT_FIRST);
        wait_cnt(16'h0001);
        chk(pwm, 1'h0);
        wait_cnt(16'h0005);
        chk(pwm, 1'h1);
        // down slope ends the period back at zero
        wait_cnt(16'h0000);
        req(3, 16'h0004);
        chk(dty, 16'h0004);
        chk(pend, 1'h0);
        // center duty zero keeps the line inactive for a full period
        req(1, 16'h0000);
        repeat (2) @(negedge CLK_IN);
        for (int i = 0; i < 100; i++) begin
            @(negedge CLK_IN);
            chk(pwm, 1'h1);
        end
        req(5, 16'h0000);
        chk(act, 1'h0);
        chk(pwm, 1'h1);
        final_report();
    end
endmodule
`default_nettype wire
